/* File: pkg/rtc_pkg.sv */
/*
 Shared constants and types for the recording trigger controller.
 Assumes a fixed channel count and sample width for the carried sample.
*/
package rtc_pkg;
  // ----------------------------------------------------------------
  // Sample shape
  // ----------------------------------------------------------------
  localparam int NCH  = 20;
  localparam int DW   = 16;
  localparam int NLOG = 12;

  typedef struct packed {
    logic [NLOG-1:0]   lg;
    logic [NCH*DW-1:0] an;
  } rtc_sample_t;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_CMD     = 12'h004;
  localparam logic [11:0] OFS_STATUS  = 12'h008;
  localparam logic [11:0] OFS_LENGTH  = 12'h00C;
  localparam logic [11:0] OFS_PRETRIG = 12'h010;
  localparam logic [11:0] OFS_PERIOD  = 12'h014;
  localparam logic [11:0] OFS_CHEN    = 12'h018;
  localparam logic [11:0] OFS_STORED  = 12'h01C;
  localparam logic [11:0] OFS_COND0   = 12'h020;
  localparam logic [11:0] OFS_COND1   = 12'h024;
  localparam logic [11:0] OFS_LOGIC0  = 12'h028;
  localparam logic [11:0] OFS_LOGIC1  = 12'h02C;
  localparam logic [11:0] OFS_CMB     = 12'h030;
  localparam logic [11:0] OFS_LEVEL   = 12'h040;
  localparam logic [11:0] OFS_CH_BASE = 12'h100;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int CMD_RECORD = 0;
  localparam int CMD_START  = 1;
  localparam int CMD_STOP   = 2;
  localparam int LEN_MAX    = 31;
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_TRIG   = 2'h1;
  localparam logic [1:0] MODE_AUTO   = 2'h2;
  localparam logic [1:0] SRC_NONE    = 2'h0;
  localparam logic [1:0] SRC_SINGLE  = 2'h1;
  localparam logic [1:0] SRC_COMBO   = 2'h2;
  localparam logic [1:0] SRC_LOGIC   = 2'h3;
  localparam logic [1:0] THR_HIGH    = 2'h0;
  localparam logic [1:0] THR_LOW     = 2'h1;
  localparam logic [1:0] THR_RISE    = 2'h2;
  localparam logic [1:0] THR_FALL    = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and gain shift
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_LENGTH = 32'h8000_0000;
  localparam logic [15:0] RST_PERIOD = 16'h0001;
  localparam logic [15:0] RST_GAIN   = 16'h0100;
  localparam int          GAIN_SHIFT = 8;
endpackage

/* File: hdl/rtc_core.sv */
/*
 Recording trigger controller: condition evaluation, pre-trigger ring,
 record sequencing and APB register file.
 Assumes samples arrive synchronous to pclk, one per smp_valid pulse, and
 that the storage side accepts st_valid without back-pressure.
*/
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module rtc_core #(
  parameter int DEPTH      = 1024,
  parameter int CAPACITY   = 1048576,
  parameter int MIN_PER_CH = 2
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     smp_req,
  input  wire logic                smp_valid,
  input  wire rtc_pkg::rtc_sample_t smp_in,
  output logic                     st_valid,
  output rtc_pkg::rtc_sample_t     st_data,
  output logic      [15:0]         st_file,
  output logic                     rec_busy
);
  localparam int NCH = rtc_pkg::NCH;
  localparam int DW  = rtc_pkg::DW;
  localparam int AW  = $clog2(DEPTH);
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 65536 || MIN_PER_CH < 1) begin : g_bad
    $error("rtc_core: DEPTH must be a power of two in 4..65536");
  end
  typedef enum logic [2:0] {S_IDLE, S_ARMED, S_REC, S_DRAIN} rtc_state_t;
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0]        ctrl_ff;
  logic [31:0]       len_ff;
  logic [15:0]       pre_ff;
  logic [15:0]       per_ff;
  logic [NCH-1:0]    chen_ff;
  logic [10:0]       cond_ff [2];
  logic [31:0]       logic_ff [2];
  logic [NCH-1:0]    cmb_ff [2][2];
  logic [17:0]       thr_ff [NCH][2];
  logic [15:0]       gain_ff [NCH];
  logic [15:0]       off_ff [NCH];
  logic              pready_ff;
  logic [31:0]       prdata_ff;
  logic              pslverr_ff;
  rtc_state_t        state_ff;
  logic [15:0]       file_ff;
  logic [31:0]       cnt_ff;
  logic [AW-1:0]     wr_ff;
  logic [AW-1:0]     rd_ff;
  logic [15:0]       have_ff;
  logic [15:0]       div_ff;
  logic              req_ff;
  logic              stv_ff;
  rtc_pkg::rtc_sample_t std_ff;
  rtc_pkg::rtc_sample_t mem [DEPTH];
  logic signed [31:0] prev_ff [NCH];
  logic              prev_ok_ff;
  logic [1:0]        lprev_ff;
  wire [1:0] start_mode = ctrl_ff[1:0];
  wire [1:0] stop_mode  = ctrl_ff[3:2];
  wire       rearm      = ctrl_ff[4];
  wire       trig_run   = ctrl_ff[5];
  // ----------------------------------------------------------------
  // Bus access decode
  // ----------------------------------------------------------------
  wire       acc    = psel & penable & pready_ff;
  wire       wen    = acc & pwrite;
  wire [7:0] ch_sel = 8'(paddr[11:4] - 8'h10);
  wire       ch_hit = (paddr >= rtc_pkg::OFS_CH_BASE) && (ch_sel < 8'(NCH));
  wire       cmd_wr = wen && paddr == rtc_pkg::OFS_CMD;
  wire       c_rec  = cmd_wr & pwdata[rtc_pkg::CMD_RECORD];
  wire       c_go   = cmd_wr & pwdata[rtc_pkg::CMD_START];
  wire       c_end  = cmd_wr & pwdata[rtc_pkg::CMD_STOP];
  // ----------------------------------------------------------------
  // Per-channel scaling and threshold tests
  // ----------------------------------------------------------------
  logic signed [31:0]   scl [NCH];
  logic [1:0][NCH-1:0]  hit;
  logic [1:0][NCH-1:0]  lvl;
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire signed [DW-1:0] raw  = smp_in.an[c*DW +: DW];
    wire signed [31:0]   prod = 32'(raw * $signed(gain_ff[c]));
    // Unit and scale applied before any compare
    assign scl[c] = (prod >>> rtc_pkg::GAIN_SHIFT) + 32'($signed(off_ff[c]));
    for (genvar k = 0; k < 2; k++) begin : g_thr
      wire signed [31:0] t  = 32'($signed(thr_ff[c][k][15:0]));
      wire [1:0]         md = thr_ff[c][k][17:16];
      wire ab  = scl[c] > t;
      wire bl  = scl[c] < t;
      wire rse = prev_ok_ff && prev_ff[c] <= t && ab;
      wire fal = prev_ok_ff && prev_ff[c] >= t && bl;
      // Two thresholds, each with its own test
      assign hit[k][c] = md == rtc_pkg::THR_HIGH ? ab :
                         md == rtc_pkg::THR_LOW  ? bl :
                         md == rtc_pkg::THR_RISE ? rse : fal;
      // Level-only view for alarm style status
      assign lvl[k][c] = md[0] ? bl : ab;
    end
  end
  // ----------------------------------------------------------------
  // Start (0) and stop (1) condition evaluation
  // ----------------------------------------------------------------
  logic [1:0] cond;
  logic [1:0] lpat;
  for (genvar j = 0; j < 2; j++) begin : g_cond
    wire [1:0]        src  = cond_ff[j][1:0];
    wire [4:0]        ch   = cond_ff[j][6:2];
    wire              ts   = cond_ff[j][7];
    wire [2*NCH-1:0]  en   = {cmb_ff[j][1], cmb_ff[j][0]};
    wire [2*NCH-1:0]  h    = {hit[1], hit[0]};
    wire              sgl  = (ch < 5'(NCH)) && hit[ts][ch];
    wire              cand = (en != '0) && ((h & en) == en);
    wire              cor  = |(h & en);
    wire [15:0]       care = logic_ff[j][15:0];
    wire [15:0]       bits = 16'(smp_in.lg);
    wire [15:0]       m    = ~(bits ^ logic_ff[j][31:16]) & care;
    assign lpat[j] = cond_ff[j][9] ? (care != '0 && m == care) : |m;
    wire              lev  = cond_ff[j][10] ? lpat[j] & ~lprev_ff[j] : lpat[j];
    assign cond[j] = src == rtc_pkg::SRC_SINGLE ? sgl :
                     src == rtc_pkg::SRC_COMBO  ? (cond_ff[j][8] ? cand : cor) :
                     src == rtc_pkg::SRC_LOGIC  ? lev : 1'b0;
  end
  // Previous sample kept for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ok_ff <= 1'b0;
      lprev_ff   <= 2'h0;
      for (int c = 0; c < NCH; c++) prev_ff[c] <= 32'h0000_0000;
    end else if (smp_valid) begin
      prev_ok_ff <= 1'b1;
      lprev_ff   <= lpat;
      for (int c = 0; c < NCH; c++) prev_ff[c] <= scl[c];
    end
  end
  // ----------------------------------------------------------------
  // Configuration checks and limits
  // ----------------------------------------------------------------
  logic [5:0] ncnt;
  always_comb begin
    ncnt = 6'h00;
    for (int c = 0; c < NCH; c++) ncnt = ncnt + 6'(chen_ff[c]);
  end
  wire [47:0] need    = 48'(len_ff[23:0]) * 48'(ncnt);
  wire        len_max = len_ff[rtc_pkg::LEN_MAX];
  wire        imposs  = ncnt == 6'h00 ||
                        32'(per_ff) < 32'(MIN_PER_CH) * 32'(ncnt) ||
                        (!len_max && need > 48'(CAPACITY));
  wire [31:0] limit   = len_max ? 32'(CAPACITY) / 32'(ncnt == 6'h00 ? 6'h01 : ncnt) :
                                  32'(len_ff[23:0]);
  wire [15:0] pre_eff = pre_ff > 16'(DEPTH - 2) ? 16'(DEPTH - 2) : pre_ff;
  wire        rearm_ok = rearm && start_mode != rtc_pkg::MODE_MANUAL &&
                         stop_mode != rtc_pkg::MODE_MANUAL;
  // ----------------------------------------------------------------
  // Record sequencing
  // ----------------------------------------------------------------
  wire wr_en   = smp_valid && (state_ff == S_ARMED || state_ff == S_REC);
  wire rd_en   = (state_ff == S_REC || state_ff == S_DRAIN) && rd_ff != wr_ff;
  wire full    = rd_en && (cnt_ff + 32'h1 >= limit);
  wire drained = state_ff == S_DRAIN && rd_ff == wr_ff;
  wire finish  = full || drained;
  wire go      = (state_ff == S_IDLE && c_rec && !imposs) || (finish && rearm_ok);
  wire imm     = start_mode == rtc_pkg::MODE_AUTO ||
                 (start_mode == rtc_pkg::MODE_TRIG && !trig_run);
  wire fire    = state_ff == S_ARMED &&
                 (start_mode == rtc_pkg::MODE_TRIG ? smp_valid & cond[0] : c_go);
  wire stop_ev = state_ff == S_REC &&
                 ((stop_mode == rtc_pkg::MODE_TRIG && smp_valid && cond[1]) || c_end);
  // Main state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
    end else if (go) begin
      state_ff <= imm ? S_REC : S_ARMED;
    end else if (finish) begin
      state_ff <= S_IDLE;
    end else begin
      case (state_ff)
        S_ARMED: begin
          if (c_end) state_ff <= S_IDLE;
          else if (fire) state_ff <= S_REC;
        end
        S_REC: begin
          if (stop_ev) state_ff <= S_DRAIN;
        end
        default: state_ff <= state_ff;
      endcase
    end
  end
  // File number, bumped for each rearmed file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_ff <= 16'h0000;
    end else if (finish && rearm_ok) begin
      file_ff <= file_ff + 16'h0001;
    end
  end
  // History ring write side and pre-trigger fill
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ff   <= '0;
      have_ff <= 16'h0000;
    end else begin
      if (wr_en) wr_ff <= wr_ff + AW'(1);
      if (go) have_ff <= 16'h0000;
      else if (state_ff == S_ARMED && wr_en && !fire && have_ff < pre_eff)
        have_ff <= have_ff + 16'h0001;
    end
  end
  always_ff @(posedge pclk) begin
    if (wr_en) mem[wr_ff] <= smp_in;
  end
  // Read side: history first, then live samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ff  <= '0;
      cnt_ff <= 32'h0000_0000;
      stv_ff <= 1'b0;
      std_ff <= '0;
    end else begin
      stv_ff <= rd_en;
      if (rd_en) std_ff <= mem[rd_ff];
      if (go) begin
        rd_ff  <= wr_ff;
        cnt_ff <= 32'h0000_0000;
      end else if (fire) begin
        rd_ff <= wr_ff - AW'(have_ff);
      end else if (rd_en) begin
        rd_ff  <= rd_ff + AW'(1);
        cnt_ff <= cnt_ff + 32'h0000_0001;
      end
    end
  end
  // Sample request divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 16'h0000;
      req_ff <= 1'b0;
    end else if (state_ff == S_ARMED || state_ff == S_REC) begin
      req_ff <= div_ff == 16'h0000;
      div_ff <= div_ff == 16'h0000 ? per_ff - 16'h0001 : div_ff - 16'h0001;
    end else begin
      div_ff <= 16'h0000;
      req_ff <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Register file write side
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 6'h00;
      len_ff  <= rtc_pkg::RST_LENGTH;
      pre_ff  <= 16'h0000;
      per_ff  <= rtc_pkg::RST_PERIOD;
      chen_ff <= '0;
      for (int j = 0; j < 2; j++) begin
        cond_ff[j]   <= 11'h000;
        logic_ff[j]  <= 32'h0000_0000;
        cmb_ff[j][0] <= '0;
        cmb_ff[j][1] <= '0;
      end
      for (int c = 0; c < NCH; c++) begin
        thr_ff[c][0] <= 18'h00000;
        thr_ff[c][1] <= 18'h00000;
        gain_ff[c]   <= rtc_pkg::RST_GAIN;
        off_ff[c]    <= 16'h0000;
      end
    end else if (wen) begin
      if (paddr == rtc_pkg::OFS_CTRL) ctrl_ff <= pwdata[5:0];
      else if (paddr == rtc_pkg::OFS_LENGTH) len_ff <= {pwdata[31], 7'h00, pwdata[23:0]};
      else if (paddr == rtc_pkg::OFS_PRETRIG) pre_ff <= pwdata[15:0];
      else if (paddr == rtc_pkg::OFS_PERIOD) per_ff <= pwdata[15:0] == 16'h0000 ? 16'h0001 : pwdata[15:0];
      else if (paddr == rtc_pkg::OFS_CHEN) chen_ff <= pwdata[NCH-1:0];
      else if (paddr == rtc_pkg::OFS_COND0) cond_ff[0] <= pwdata[10:0];
      else if (paddr == rtc_pkg::OFS_COND1) cond_ff[1] <= pwdata[10:0];
      else if (paddr == rtc_pkg::OFS_LOGIC0) logic_ff[0] <= pwdata;
      else if (paddr == rtc_pkg::OFS_LOGIC1) logic_ff[1] <= pwdata;
      else if (paddr[11:4] == rtc_pkg::OFS_CMB[11:4])
        cmb_ff[paddr[3]][paddr[2]] <= pwdata[NCH-1:0];
      else if (ch_hit) begin
        if (paddr[3:2] == 2'h0) thr_ff[ch_sel[4:0]][0] <= pwdata[17:0];
        else if (paddr[3:2] == 2'h1) thr_ff[ch_sel[4:0]][1] <= pwdata[17:0];
        else if (paddr[3:2] == 2'h2) gain_ff[ch_sel[4:0]] <= pwdata[15:0];
        else off_ff[ch_sel[4:0]] <= pwdata[15:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // Register file read side, one wait state
  // ----------------------------------------------------------------
  logic [31:0] rdv;
  logic        rerr;
  always_comb begin
    rdv  = 32'h0000_0000;
    rerr = 1'b0;
    if (paddr == rtc_pkg::OFS_CTRL) rdv = 32'(ctrl_ff);
    else if (paddr == rtc_pkg::OFS_CMD) rdv = 32'h0000_0000;
    else if (paddr == rtc_pkg::OFS_STATUS) rdv = {file_ff, 13'h0000, imposs, 2'(state_ff)};
    else if (paddr == rtc_pkg::OFS_LENGTH) rdv = len_ff;
    else if (paddr == rtc_pkg::OFS_PRETRIG) rdv = 32'(pre_ff);
    else if (paddr == rtc_pkg::OFS_PERIOD) rdv = 32'(per_ff);
    else if (paddr == rtc_pkg::OFS_CHEN) rdv = 32'(chen_ff);
    else if (paddr == rtc_pkg::OFS_STORED) rdv = cnt_ff;
    else if (paddr == rtc_pkg::OFS_COND0) rdv = 32'(cond_ff[0]);
    else if (paddr == rtc_pkg::OFS_COND1) rdv = 32'(cond_ff[1]);
    else if (paddr == rtc_pkg::OFS_LOGIC0) rdv = logic_ff[0];
    else if (paddr == rtc_pkg::OFS_LOGIC1) rdv = logic_ff[1];
    else if (paddr[11:4] == rtc_pkg::OFS_CMB[11:4]) rdv = 32'(cmb_ff[paddr[3]][paddr[2]]);
    else if (paddr == rtc_pkg::OFS_LEVEL) rdv = 32'(lvl[0] | lvl[1]);
    else if (ch_hit) begin
      if (paddr[3:2] == 2'h0) rdv = 32'(thr_ff[ch_sel[4:0]][0]);
      else if (paddr[3:2] == 2'h1) rdv = 32'(thr_ff[ch_sel[4:0]][1]);
      else if (paddr[3:2] == 2'h2) rdv = 32'(gain_ff[ch_sel[4:0]]);
      else rdv = 32'(off_ff[ch_sel[4:0]]);
    end else rerr = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & rerr;
      if (psel & penable & ~pready_ff & ~pwrite) prdata_ff <= rdv;
    end
  end
  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign smp_req  = req_ff;
  assign st_valid = stv_ff;
  assign st_data  = std_ff;
  assign st_file  = file_ff;
  // Busy flag for the storage side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rec_busy <= 1'b0;
    else rec_busy <= state_ff == S_REC || state_ff == S_DRAIN;
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  refuse_bad_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == S_IDLE && c_rec && imposs |=> state_ff == S_IDLE) else $error("bad config started");
  auto_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && start_mode == rtc_pkg::MODE_AUTO |=> state_ff == S_REC) else $error("auto start late");
  arm_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && start_mode == rtc_pkg::MODE_TRIG && trig_run |=> state_ff == S_ARMED) else $error("not armed");
  start_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
    fire && !c_end && !go |=> state_ff == S_REC && (rd_en || !$past(smp_valid))) else $error("start missed");
  stop_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
    stop_ev && !finish |=> state_ff == S_DRAIN) else $error("stop missed");
  count_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == S_REC |-> cnt_ff < limit || limit == 32'h0) else $error("overran length");
  pre_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == S_ARMED |-> have_ff <= pre_eff) else $error("history too long");
  file_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && rearm_ok |=> file_ff == $past(file_ff) + 16'h0001 && state_ff != S_IDLE) else $error("no new file");
  out_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_valid |-> $past(state_ff) == S_REC || $past(state_ff) == S_DRAIN) else $error("stray store");
endmodule

/* File: dv/rtc_front_model.sv */
/*
 Acquisition front end model: answers each sample request with one sample.
 Assumes smp_req pulses for one cycle; channel 0 carries 16 times the sample index.
*/
`timescale 1ns/1ps
module rtc_front_model (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           smp_req,
  output logic                smp_valid,
  output rtc_pkg::rtc_sample_t smp_in
);
  localparam int SW = $bits(rtc_pkg::rtc_sample_t);
  logic [15:0] idx_ff;

  // One sample a cycle after each request; idle data toggles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_valid <= 1'b0;
      smp_in    <= '0;
      idx_ff    <= 16'h0000;
    end else if (smp_req) begin
      smp_valid      <= 1'b1;
      smp_in         <= rtc_pkg::rtc_sample_t'(SW'({idx_ff[11:0], 4'h0}));
      idx_ff         <= idx_ff + 16'h0001;
    end else begin
      smp_valid <= 1'b0;
      smp_in    <= ~smp_in; // Not held past the valid cycle
    end
  end
endmodule

/* File: dv/recording_trigger_control_bench.sv */
/*
 Self-checking bench: APB register access, impossible checks, trigger start
 with pre-trigger history and rearm, automatic start to full length.
 Assumes the front end model above and a 100 MHz pclk.
*/
`timescale 1ns/1ps
module recording_trigger_control_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, perr, smp_req, smp_valid, st_valid, rec_busy;
  rtc_pkg::rtc_sample_t smp_in, st_data;
  logic [15:0] st_file, first_an;
  int n_fail = 0, n_tests = 0, n_st = 0, base = 0;

  always #5 pclk = ~pclk;

  rtc_core #(.DEPTH(16), .CAPACITY(1048576), .MIN_PER_CH(2)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .smp_req(smp_req), .smp_valid(smp_valid), .smp_in(smp_in),
    .st_valid(st_valid), .st_data(st_data), .st_file(st_file), .rec_busy(rec_busy));
  rtc_front_model fe (.pclk(pclk), .presetn(presetn), .smp_req(smp_req), .smp_valid(smp_valid), .smp_in(smp_in));

  // Count stored samples and keep the first one
  always @(posedge pclk) begin
    if (st_valid === 1'b1) begin
      if (n_st == 0) first_an = st_data.an[15:0];
      n_st = n_st + 1;
    end
  end

  // ------------------------------------------------------------
  // Bus, check and wait tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      n_fail++;
      $display("CHECK FAILED %0t no pready", $time);
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_st(input int n);
    int i;
    for (i = 0; i < 3000 && n_st < n; i++) @(posedge pclk);
    if (n_st < n) begin
      n_fail++;
      $display("CHECK FAILED %0t stored samples missing", $time);
    end
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, rtc_pkg::OFS_LENGTH, 0); chk(rdat, rtc_pkg::RST_LENGTH);
    apb(1'b0, rtc_pkg::OFS_PERIOD, 0); chk(rdat, 32'h0000_0001);
    apb(1'b0, 12'hFFC, 0); chk({perr, rdat[30:0]}, 32'h8000_0000);
    apb(1'b0, rtc_pkg::OFS_STATUS, 0); chk(rdat[2], 1'b1);
    wr(rtc_pkg::OFS_CHEN, 32'h0000_0001);
    apb(1'b0, rtc_pkg::OFS_STATUS, 0); chk(rdat[2], 1'b1);
    wr(rtc_pkg::OFS_PERIOD, 32'h0000_0002);
    wr(rtc_pkg::OFS_LENGTH, 32'h0000_0004);
    apb(1'b0, rtc_pkg::OFS_STATUS, 0); chk(rdat[2], 1'b0);
    // Trigger start, level above 0x50, two samples of history, rearm
    wr(rtc_pkg::OFS_CH_BASE, 32'h0000_0050);
    wr(rtc_pkg::OFS_CH_BASE + 12'h004, 32'h0002_0070);
    apb(1'b0, rtc_pkg::OFS_CH_BASE + 12'h004, 0); chk(rdat, 32'h0002_0070);
    wr(rtc_pkg::OFS_COND0, 32'h0000_0001);
    wr(rtc_pkg::OFS_PRETRIG, 32'h0000_0002);
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0039);
    wr(rtc_pkg::OFS_CMD, 32'h0000_0001);
    wait_st(4);
    chk({16'h0, first_an}, 32'h0000_0040);
    chk(n_st, 4);
    chk({16'h0, st_file}, 32'h0000_0001);
    apb(1'b0, rtc_pkg::OFS_STATUS, 0); chk(rdat[31:16], 16'h0001);
    // Second rearmed file of four samples bumps the number again
    wait_st(8);
    chk({16'h0, st_file}, 32'h0000_0002);
    // Rearm off first, then abort whatever is still running
    wr(rtc_pkg::OFS_CTRL, 32'h0000_000A);
    wr(rtc_pkg::OFS_CMD, 32'h0000_0004);
    repeat (40) @(posedge pclk);
    // Automatic start runs to full length
    base = n_st;
    wr(rtc_pkg::OFS_CMD, 32'h0000_0001);
    wait_st(base + 1);
    chk(rec_busy, 1'b1);
    wait_st(base + 4);
    repeat (40) @(posedge pclk);
    chk(n_st - base, 4);
    apb(1'b0, rtc_pkg::OFS_STATUS, 0); chk(rdat[1:0], 2'h0);
    chk(rec_busy, 1'b0);
    close_out();
  end

  // Watchdog for a hung wait
  initial begin
    #200us;
    n_fail++;
    close_out();
  end
endmodule
